// [rsp_pkg.sv]
// Purpose: Shared constants and types for the radio serial register/FIFO port.
// Assumes: Mode-0 serial slave, address byte is write flag plus seven-bit address.
// Notes: Widths and encodings used by the port and its testbench live here.
package rsp_pkg;
  // ----------------------------------------------------------------------
  // Framing constants
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int unsigned WFLAG_POS = 7;
  localparam logic [6:0] FIFO_ADDR = 7'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------------------------------------
  // Packet-mode payload limits
  // ----------------------------------------------------------------------
  localparam int unsigned PAYLOAD_MAX_SHORT = 255;
  localparam int unsigned PAYLOAD_MAX_LONG = 2047;
  localparam int unsigned LEN_W = 11;

  typedef enum logic [1:0] {
    RSP_LIM_SHORT,
    RSP_LIM_LONG,
    RSP_LIM_NONE
  } rsp_limit_t;

  typedef enum logic {
    RSP_MODE_CONTINUOUS,
    RSP_MODE_PACKET
  } rsp_mode_t;

  // Register access request toward the configuration register file.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [6:0] addr;
    logic [7:0] data;
  } rsp_reg_req_t;

  // Payload byte exchanged with the packet FIFO.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rsp_byte_t;
endpackage : rsp_pkg

// [rsp_sync.sv]
// Purpose: Two-flop synchroniser for the serial pins.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module rsp_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  if (WIDTH < 1) begin : g_bad_width
    $error("rsp_sync needs at least one bit");
  end

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else if (clkEn) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : rsp_sync

// [rsp_port.sv]
// Purpose: Serial slave port reaching configuration registers and the packet FIFO.
// Assumes: The serial clock is oversampled by sys_clk at 200 MHz.
// Notes: The register file and packet engine sit outside; this block frames bytes.
`timescale 1ns/100ps
// Functional notes
// RULE1: Two data modes; only the selected mode's datapath is enabled.
// RULE2: Continuous mode passes raw bits live on the continuous data pin.
// RULE3: Packet mode host exchanges only payload bytes with the FIFO.
// RULE4: Packet engine adds preamble, sync, optional CRC and DC-free coding.
// RULE5: Payload limit is 255, 2047 bytes or unlimited by feature set.
// RULE6: Mode 0: clock idles low, data sampled on rising edge.
// RULE7: Only the slave role; host drives clock and chip select.
// RULE8: Single write is address byte then data byte in one frame.
// RULE9: Single read returns addressed register as the byte after address.
// RULE10: Host frames single access with chip select low for one data byte.
// RULE11: Burst access increments the address after every data byte.
// RULE12: Burst works for both reads and writes.
// RULE13: Host keeps chip select low across every byte of burst or FIFO.
// RULE14: Address equal to FIFO routes all following bytes to the FIFO.
// RULE15: FIFO access keeps the address fixed between data bytes.
// RULE16: Address byte is write flag then seven address bits, MSB first.
// RULE17: Sample on rising edge, change on falling, release output when deselected.
module rsp_port #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic serialClk,
  input wire logic chip_select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic modeSel,
  input wire logic crcOn,
  input wire logic lengthExtOn,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] fifoRdData,
  output rsp_pkg::rsp_reg_req_t regReq,
  output rsp_pkg::rsp_byte_t fifoWr,
  output logic fifoRdPop,
  output logic contEnable,
  output logic packetEnable,
  output rsp_pkg::rsp_limit_t payloadLimit,
  input wire logic contRxBit,
  output logic contTxBit,
  input wire logic continuous_data_pin_in,
  output logic continuous_data_pin_out,
  output logic continuous_data_pin_oe,
  input wire logic contTxDir
);
  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("rsp_port supports two sync stages only");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [3:0] pinSync;
  logic sclkS, csnS, mosiS, dataPinS;
  rsp_sync #(.WIDTH(4), .INIT(4'h2)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEn(clkEn),
    .asyncIn({continuous_data_pin_in, serialIn, chip_select_n, serialClk}),
    .syncOut(pinSync)
  );
  assign sclkS = pinSync[0];
  assign csnS = pinSync[1];
  assign mosiS = pinSync[2];
  assign dataPinS = pinSync[3];

  logic sclkPrev_q;
  logic rise, fall, active;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) sclkPrev_q <= 1'b0;
    else if (clkEn) sclkPrev_q <= sclkS;
  end
  assign active = !csnS; // RULE7
  assign rise = active && sclkS && !sclkPrev_q; // RULE6
  assign fall = active && !sclkS && sclkPrev_q; // RULE6

  // ----------------------------------------------------------------------
  // Receive shifter and byte framing
  // ----------------------------------------------------------------------
  logic [2:0] bitCnt_q;
  logic [6:0] shift_q;
  logic [7:0] rxByte;
  logic byteDone;
  assign rxByte = {shift_q, mosiS};
  assign byteDone = rise && (bitCnt_q == rsp_pkg::BIT_LAST);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bitCnt_q <= '0;
      shift_q <= '0;
    end else if (clkEn) begin
      if (!active) begin
        bitCnt_q <= '0;
      end else if (rise) begin
        shift_q <= rxByte[6:0]; // RULE16
        bitCnt_q <= bitCnt_q + 3'h1;
      end
    end
  end

  typedef enum logic {
    ST_ADDR,
    ST_DATA
  } rsp_state_t;
  rsp_state_t state_q;
  logic write_flag_q;
  logic [6:0] addr_q;
  logic isFifo;
  assign isFifo = (addr_q == rsp_pkg::FIFO_ADDR);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_ADDR;
      write_flag_q <= 1'b0;
      addr_q <= rsp_pkg::ADDR_RESET;
    end else if (clkEn) begin
      if (!active) begin
        state_q <= ST_ADDR;
      end else if (byteDone) begin
        case (state_q)
          ST_ADDR: begin
            write_flag_q <= rxByte[rsp_pkg::WFLAG_POS]; // RULE16
            addr_q <= rxByte[6:0];
            state_q <= ST_DATA;
          end
          ST_DATA: begin
            if (!isFifo) addr_q <= addr_q + 7'h01; // RULE11 RULE12
            // FIFO address stays put for the next byte. // RULE15
          end
          default: state_q <= ST_ADDR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register and FIFO requests
  // ----------------------------------------------------------------------
  logic addrDone, needRead;
  assign addrDone = byteDone && (state_q == ST_ADDR);
  assign needRead = (addrDone && !rxByte[rsp_pkg::WFLAG_POS])
    || (byteDone && state_q == ST_DATA && !write_flag_q);

  logic [6:0] rdAddr;
  assign rdAddr = addrDone ? rxByte[6:0] : (isFifo ? addr_q : addr_q + 7'h01);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regReq <= '0;
      fifoWr <= '0;
      fifoRdPop <= 1'b0;
    end else if (clkEn) begin
      regReq.wrEn <= 1'b0;
      regReq.rdEn <= 1'b0;
      fifoWr.valid <= 1'b0;
      fifoRdPop <= 1'b0;
      if (byteDone && state_q == ST_DATA && write_flag_q) begin
        if (isFifo && packetEnable) begin
          fifoWr.valid <= 1'b1; // RULE14 RULE3
          fifoWr.data <= rxByte;
        end else if (!isFifo) begin
          regReq.wrEn <= 1'b1; // RULE8
          regReq.addr <= addr_q;
          regReq.data <= rxByte;
        end
      end else if (needRead) begin
        if (rdAddr == rsp_pkg::FIFO_ADDR) begin
          fifoRdPop <= packetEnable; // RULE14 RULE3
        end else begin
          regReq.rdEn <= 1'b1; // RULE9
        end
        regReq.addr <= rdAddr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------------
  logic loadPend_q;
  logic [7:0] txShift_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) loadPend_q <= 1'b0;
    else if (clkEn) loadPend_q <= needRead;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      txShift_q <= rsp_pkg::BYTE_ZERO;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (clkEn) begin
      serialOutEn <= active; // RULE17
      if (!active) begin
        serialOut <= 1'b0;
        txShift_q <= rsp_pkg::BYTE_ZERO;
      end else if (loadPend_q) begin
        txShift_q <= (regReq.addr == rsp_pkg::FIFO_ADDR) ? fifoRdData : regRdData; // RULE9
      end else if (fall) begin
        serialOut <= txShift_q[7]; // RULE17 RULE16
        txShift_q <= {txShift_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data operation mode and continuous data path
  // ----------------------------------------------------------------------
  // The pin path decodes the mode itself so that it never outlives contEnable.
  logic contSel;
  assign contSel = (modeSel == rsp_pkg::RSP_MODE_CONTINUOUS);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      contEnable <= 1'b0;
      packetEnable <= 1'b1;
      payloadLimit <= rsp_pkg::RSP_LIM_SHORT;
    end else if (clkEn) begin
      contEnable <= contSel; // RULE1
      packetEnable <= (modeSel == rsp_pkg::RSP_MODE_PACKET); // RULE1 RULE4
      if (lengthExtOn && !crcOn) payloadLimit <= rsp_pkg::RSP_LIM_NONE; // RULE5
      else if (lengthExtOn) payloadLimit <= rsp_pkg::RSP_LIM_LONG; // RULE5
      else payloadLimit <= rsp_pkg::RSP_LIM_SHORT; // RULE5
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      continuous_data_pin_out <= 1'b0;
      continuous_data_pin_oe <= 1'b0;
      contTxBit <= 1'b0;
    end else if (clkEn) begin
      continuous_data_pin_oe <= contSel && !contTxDir; // RULE2
      continuous_data_pin_out <= contSel ? contRxBit : 1'b0; // RULE2
      contTxBit <= (contSel && contTxDir) ? dataPinS : 1'b0; // RULE2
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence addrByteSeq;
    addrDone && !rxByte[rsp_pkg::WFLAG_POS];
  endsequence

  out_released_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE17
    clkEn && csnS |=> !serialOutEn) else $error("output driven while deselected");
  read_issue_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE9
    (clkEn and addrByteSeq) |=> (regReq.rdEn || fifoRdPop || !$past(packetEnable)))
    else $error("no read after address");
  burst_inc_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE11
    clkEn && byteDone && state_q == ST_DATA && !isFifo |=> addr_q == $past(addr_q) + 7'h01)
    else $error("burst address not incremented");
  fifo_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE15
    clkEn && byteDone && state_q == ST_DATA && isFifo |=> addr_q == rsp_pkg::FIFO_ADDR)
    else $error("fifo address moved");
  write_req_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    clkEn && byteDone && state_q == ST_DATA && write_flag_q && !isFifo
    |=> regReq.wrEn && regReq.data == $past(rxByte)) else $error("write lost");
  fifo_route_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE14
    clkEn && byteDone && state_q == ST_DATA && write_flag_q && isFifo && packetEnable
    |=> fifoWr.valid && !regReq.wrEn) else $error("fifo byte misrouted");
  mode_excl_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    !(contEnable && packetEnable)) else $error("both data modes enabled");
  cont_pin_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    continuous_data_pin_oe |-> contEnable) else $error("data pin driven outside continuous");
  frame_reset_a: assert property (@(posedge sys_clk) disable iff (reset) // RULE16
    clkEn && csnS |=> state_q == ST_ADDR && bitCnt_q == 3'h0) else $error("frame not reset");
endmodule : rsp_port

// [rsp_host_model.sv]
// Purpose: Behavioural serial host that frames bytes toward the port.
// Assumes: Mode 0 with a 48 ns serial clock period.
// Notes: Edges sit off the sys_clk grid; data line inverts outside frames.
`timescale 1ns/100ps
module rsp_host_model (
  input wire logic sys_clk,
  input wire logic serialOut,
  input wire logic serialOutEn,
  output logic serialClk,
  output logic chip_select_n,
  output logic serialIn
);
  localparam int HALF_NS = 24;

  initial begin
    serialClk = 1'b0;
    chip_select_n = 1'b1;
    serialIn = 1'b0;
  end

  task automatic begin_frame();
    @(posedge sys_clk);
    #1.5 chip_select_n = 1'b0;
    #(HALF_NS);
  endtask : begin_frame

  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serialIn = tx[i];
      #(HALF_NS) serialClk = 1'b1;
      // A released line shows the inverse of serialOut, which the port clears to 0 while deselected.
      rx[i] = serialOutEn ? serialOut : ~serialOut;
      #(HALF_NS) serialClk = 1'b0;
    end
  endtask : xfer_byte

  task automatic end_frame();
    #(HALF_NS) chip_select_n = 1'b1;
    serialIn = ~serialIn;
    #(2 * HALF_NS);
  endtask : end_frame
endmodule : rsp_host_model

// [testbench.sv]
// Purpose: Self-checking bench for the serial register and FIFO port.
// Assumes: Register file and FIFO answer within the cycle of a request pulse.
// Notes: Writes and FIFO pushes are logged into queues and checked per test.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic serialClk, chip_select_n, serialIn, serialOut, serialOutEn;
  logic modeSel = 1'b1, crcOn = 1'b0, lengthExtOn = 1'b0;
  logic [7:0] regRdData = 8'h00, fifoRdData = 8'h00, popVal = 8'h40, rx, ex;
  rsp_pkg::rsp_reg_req_t regReq;
  rsp_pkg::rsp_byte_t fifoWr;
  rsp_pkg::rsp_limit_t payloadLimit, lim;
  logic fifoRdPop, contEnable, packetEnable, contTxBit, pinOut, pinOe;
  logic contRxBit = 1'b0, pinIn = 1'b0, contTxDir = 1'b1;
  logic [14:0] wrQ[$];
  logic [7:0] fifoQ[$];
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  rsp_port uut (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .serialClk(serialClk),
    .chip_select_n(chip_select_n), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .modeSel(modeSel), .crcOn(crcOn), .lengthExtOn(lengthExtOn),
    .regRdData(regRdData), .fifoRdData(fifoRdData), .regReq(regReq), .fifoWr(fifoWr),
    .fifoRdPop(fifoRdPop), .contEnable(contEnable), .packetEnable(packetEnable),
    .payloadLimit(payloadLimit), .contRxBit(contRxBit), .contTxBit(contTxBit),
    .continuous_data_pin_in(pinIn), .continuous_data_pin_out(pinOut),
    .continuous_data_pin_oe(pinOe), .contTxDir(contTxDir));
  rsp_host_model uHost (.sys_clk(sys_clk), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .serialClk(serialClk),
    .chip_select_n(chip_select_n), .serialIn(serialIn));

  function automatic logic [7:0] rd_model(input logic [6:0] a);
    return {1'b1, a} ^ 8'h5a;
  endfunction : rd_model

  // Register file and FIFO stand-ins, logging and the cycle ceiling.
  always @(posedge sys_clk) begin
    cycles++;
    if (regReq.wrEn === 1'b1) wrQ.push_back({regReq.addr, regReq.data});
    if (fifoWr.valid === 1'b1) fifoQ.push_back(fifoWr.data);
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // Read answers appear inside the request cycle, as the port loads them one edge later.
  always @(posedge sys_clk) begin
    #1.5;
    if (regReq.rdEn === 1'b1) regRdData = rd_model(regReq.addr);
    if (fifoRdPop === 1'b1) begin
      fifoRdData = popVal;
      popVal = popVal + 8'h11;
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1.5;
  endtask : idle

  // Sends an address byte then n data bytes counting up from d.
  task automatic frame(input logic [7:0] a, input int n, input logic [7:0] d);
    uHost.begin_frame();
    uHost.xfer_byte(a, rx);
    for (int i = 0; i < n; i++) uHost.xfer_byte(d + 8'(i), rx);
    uHost.end_frame();
    idle(4);
  endtask : frame

  task automatic t_write();
    wrQ.delete();
    frame(8'h85, 1, 8'h3c);
    frame(8'h90, 3, 8'ha0);
    `CHK("wr count", 4, wrQ.size())
    `CHK("single wr", {7'h05, 8'h3c}, wrQ[0])
    for (int i = 0; i < 3; i++) `CHK("burst wr", {7'h10 + 7'(i), 8'ha0 + 8'(i)}, wrQ[i + 1])
  endtask : t_write

  task automatic t_read();
    wrQ.delete();
    uHost.begin_frame();
    uHost.xfer_byte(8'h20, rx);
    `CHK("out en", 1'b1, serialOutEn)
    for (int i = 0; i < 3; i++) begin
      uHost.xfer_byte(8'h00, rx);
      `CHK("rd data", rd_model(7'h20 + 7'(i)), rx)
    end
    uHost.end_frame();
    `CHK("out off", 1'b0, serialOutEn)
    `CHK("rd no wr", 0, wrQ.size())
  endtask : t_read

  task automatic t_fifo();
    fifoQ.delete();
    wrQ.delete();
    frame(8'h80, 3, 8'hc0);
    `CHK("fifo count", 3, fifoQ.size())
    for (int i = 0; i < 3; i++) `CHK("fifo wr", 8'hc0 + 8'(i), fifoQ[i])
    `CHK("fifo no reg", 0, wrQ.size())
    ex = popVal;
    uHost.begin_frame();
    uHost.xfer_byte(8'h00, rx);
    for (int i = 0; i < 2; i++) begin
      uHost.xfer_byte(8'h00, rx);
      `CHK("fifo rd", ex + 8'(8'h11 * i), rx)
    end
    uHost.end_frame();
    idle(4);
  endtask : t_fifo

  task automatic t_cont();
    modeSel = 1'b0;
    idle(4);
    `CHK("cont en", 1'b1, contEnable)
    `CHK("pkt off", 1'b0, packetEnable)
    fifoQ.delete();
    frame(8'h80, 1, 8'h77);
    `CHK("cont fifo", 0, fifoQ.size())
    ex = popVal;
    frame(8'h00, 1, 8'h00);
    `CHK("cont no pop", ex, popVal)
    pinIn = 1'b1;
    idle(6);
    `CHK("cont rx", 1'b1, contTxBit)
    `CHK("pin in oe", 1'b0, pinOe)
    contTxDir = 1'b0;
    contRxBit = 1'b1;
    idle(6);
    `CHK("pin oe", 1'b1, pinOe)
    `CHK("pin out", 1'b1, pinOut)
    modeSel = 1'b1;
    idle(4);
    `CHK("pkt en", 1'b1, packetEnable)
    `CHK("pin off", 1'b0, pinOe)
    `CHK("pin out off", 1'b0, pinOut)
  endtask : t_cont

  task automatic t_limit();
    for (int i = 0; i < 4; i++) begin
      {crcOn, lengthExtOn} = 2'(i);
      idle(4);
      lim = lengthExtOn ? (crcOn ? rsp_pkg::RSP_LIM_LONG : rsp_pkg::RSP_LIM_NONE)
        : rsp_pkg::RSP_LIM_SHORT;
      `CHK("limit", lim, payloadLimit)
    end
  endtask : t_limit

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  initial begin
    idle(6);
    reset = 1'b0;
    idle(8);
    t_write();
    t_read();
    t_fifo();
    t_cont();
    t_limit();
    complete_run();
  end
endmodule : testbench
